//--- dcf_ctrl_model.sv
// controller model: drives the fifo pins with slow pin clocks
// assumes aclk runs free; pins change just after aclk rising edges
`timescale 1ns/1ps
module dcf_ctrl_model
  import dcf_pkg::*;
(
  // system clock
  input  wire logic             aclk,
  // fifo pins
  output logic                  write_clock = 1'b0,
  output logic                  read_clock = 1'b0,
  output logic                  write_enable_first_n = 1'b1,
  output logic                  write_enable_second_or_load = 1'b1,
  output logic                  read_enable_first_n = 1'b1,
  output logic                  read_enable_second_n = 1'b1,
  output logic                  output_enable_n = 1'b0,
  output logic [DCF_DATA_W-1:0] write_data_in = '0
);
  // one pin-clock cycle on both sides; w and r pick a write and a read
  // enables held around the edge
  task automatic op(input logic w, input logic r, input logic [DCF_DATA_W-1:0] d);
    @(posedge aclk);
    write_enable_first_n <= ~w;
    read_enable_first_n  <= ~r;
    read_enable_second_n <= ~r;
    write_data_in        <= d;
    repeat (2) @(posedge aclk);
    write_clock <= 1'b1;
    read_clock  <= 1'b1;
    repeat (4) @(posedge aclk);
    write_clock          <= 1'b0;
    read_clock           <= 1'b0;
    write_enable_first_n <= 1'b1;
    read_enable_first_n  <= 1'b1;
    read_enable_second_n <= 1'b1;
    // released data lines show the inverse of the last word
    write_data_in        <= ~d;
    repeat (4) @(posedge aclk);
  endtask : op
  // strap and output enable levels, set before a reset
  task automatic strap(input logic ld, input logic oe);
    @(posedge aclk);
    write_enable_second_or_load <= ld;
    output_enable_n             <= oe;
  endtask : strap
endmodule : dcf_ctrl_model

//--- dcf_fifo.sv
// dual-clock fifo bank: array, pointers, status flags, offset registers, axi-lite
// assumes write_clock/read_clock are pins sampled on aclk (at most aclk/4)
`timescale 1ns/1ps
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH_DEFAULT
) (
  // system clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // fifo pins, asynchronous
  input  wire logic                  write_clock,
  input  wire logic                  read_clock,
  input  wire logic                  write_enable_first_n,
  input  wire logic                  write_enable_second_or_load,
  input  wire logic                  read_enable_first_n,
  input  wire logic                  read_enable_second_n,
  input  wire logic                  output_enable_n,
  input  wire logic [DCF_DATA_W-1:0] write_data_in,
  // fifo outputs
  output logic [DCF_DATA_W-1:0]      read_data_out,
  output logic                       read_data_oe_n,
  output logic                       full_flag_n,
  output logic                       almost_full_flag_n,
  output logic                       almost_empty_flag_n,
  output logic                       empty_flag_n,
  // axi4-lite write address and data
  input  wire logic [DCF_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read
  input  wire logic [DCF_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);

  // ****************************************************************
  // sizes
  // ****************************************************************
  // depth parameter sizing
  localparam int             AW      = $clog2(DEPTH);  // array index width
  localparam int             PW      = AW + 1;         // pointer width with wrap bit
  localparam logic [PW-1:0]  DEPTH_C = PW'(DEPTH);     // depth at pointer width
  localparam logic [16:0]    DEPTH_T = 17'(DEPTH);     // depth for threshold sums

  // binary to gray
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  // gray to binary
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
    end
    gray2bin = b;
  endfunction : gray2bin

  // ****************************************************************
  // pin synchronisers and edge detection
  // ****************************************************************
  dcf_pins_t pins_in;   // raw pin bundle
  dcf_pins_t pins_s1;   // first stage, feeds second stage only
  dcf_pins_t pins_s2;   // second stage, safe to use
  logic      wclk_d;    // delayed write clock level
  logic      rclk_d;    // delayed read clock level

  assign pins_in = '{wclk: write_clock, rclk: read_clock, write_enable_first_n_n: write_enable_first_n,
                     write_enable_second_ld: write_enable_second_or_load, ren1_n: read_enable_first_n,
                     ren2_n: read_enable_second_n, oe_n: output_enable_n,
                     wdata: write_data_in};

  // two-flop synchroniser for every pin
  always_ff @(posedge aclk) begin
    pins_s1 <= pins_in;
    pins_s2 <= pins_s1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wclk_d <= 1'b1;
      rclk_d <= 1'b1;
    end else begin
      wclk_d <= pins_s2.wclk;
      rclk_d <= pins_s2.rclk;
    end
  end

  logic w_edge;   // one-cycle pulse per write clock rise
  logic r_edge;   // one-cycle pulse per read clock rise
  assign w_edge = aresetn && pins_s2.wclk && !wclk_d;
  assign r_edge = aresetn && pins_s2.rclk && !rclk_d;

  // ****************************************************************
  // mode strap
  // ****************************************************************
  logic load_mode_r;   // 1: pin is load enable, 0: second write enable

  // sample pin level while reset held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_mode_r <= !pins_s2.write_enable_second_ld;
    end
  end

  // ****************************************************************
  // request decode
  // ****************************************************************
  dcf_flags_t flags_r;    // flag registers
  logic       wr_req;     // write edge with first write enable low
  logic       do_push;    // word stored this cycle
  logic       do_load;    // offset half loaded this cycle
  logic       rd_req;     // read edge with both enables low
  logic       do_pop;     // word read this cycle
  logic       do_ofs_rd;  // offset half shown this cycle

  assign wr_req    = w_edge && !pins_s2.write_enable_first_n_n;
  assign do_push   = wr_req && pins_s2.write_enable_second_ld && flags_r.full_n;
  // load mode with load pin low
  assign do_load   = wr_req && load_mode_r && !pins_s2.write_enable_second_ld;
  assign rd_req    = r_edge && !pins_s2.ren1_n && !pins_s2.ren2_n;
  assign do_ofs_rd = rd_req && load_mode_r && !pins_s2.write_enable_second_ld;
  assign do_pop    = rd_req && !do_ofs_rd && flags_r.empty_n;

  // ****************************************************************
  // array and pointers
  // ****************************************************************
  logic [DCF_DATA_W-1:0] mem [DEPTH];   // storage array
  logic [PW-1:0]         wptr_r;        // write pointer, binary
  logic [PW-1:0]         rptr_r;        // read pointer, binary
  logic [PW-1:0]         wgray_r;       // write pointer, gray
  logic [PW-1:0]         rgray_r;       // read pointer, gray
  logic [PW-1:0]         wptr_nxt;
  logic [PW-1:0]         rptr_nxt;

  assign wptr_nxt = do_push ? PW'(wptr_r + 1'b1) : wptr_r;
  assign rptr_nxt = do_pop  ? PW'(rptr_r + 1'b1) : rptr_r;

  // array write, no reset needed
  always_ff @(posedge aclk) begin
    if (do_push) begin
      mem[wptr_r[AW-1:0]] <= pins_s2.wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      wgray_r <= '0;
      rgray_r <= '0;
    end else begin
      wptr_r  <= wptr_nxt;
      rptr_r  <= rptr_nxt;
      wgray_r <= bin2gray(wptr_nxt);
      rgray_r <= bin2gray(rptr_nxt);
    end
  end

  // ****************************************************************
  // pointer crossing
  // ****************************************************************
  logic [PW-1:0] wg_s1, wg_s2;   // write gray into read side
  logic [PW-1:0] rg_s1, rg_s2;   // read gray into write side

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wg_s1 <= '0;
      wg_s2 <= '0;
      rg_s1 <= '0;
      rg_s2 <= '0;
    end else begin
      wg_s1 <= wgray_r;
      wg_s2 <= wg_s1;
      rg_s1 <= rgray_r;
      rg_s2 <= rg_s1;
    end
  end

  // ****************************************************************
  // offset registers
  // ****************************************************************
  logic [DCF_OFS_W-1:0] eofs_r;     // empty offset n
  logic [DCF_OFS_W-1:0] fofs_r;     // full offset m
  dcf_sel_t             wsel_r;     // next offset half to load
  dcf_sel_t             rsel_r;     // next offset half to show
  logic                 axi_wr;     // axi write performed
  logic [DCF_AXI_AW-1:0] awaddr_r;  // latched write address
  logic [31:0]          wdata_r;    // latched write data
  logic [3:0]           wstrb_r;    // latched byte enables

  // merge axi byte lanes into an offset
  function automatic logic [DCF_OFS_W-1:0] lane_merge(input logic [DCF_OFS_W-1:0] old,
                                                     input logic [31:0] d,
                                                     input logic [3:0] s);
    lane_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : lane_merge

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eofs_r <= DCF_OFS_DEFAULT;
      fofs_r <= DCF_OFS_DEFAULT;
    end else if (do_load) begin
      unique case (wsel_r)
        DCF_SEL_ELO: eofs_r[DCF_BYTE_W-1:0]         <= pins_s2.wdata[DCF_BYTE_W-1:0];
        DCF_SEL_EHI: eofs_r[DCF_OFS_W-1:DCF_BYTE_W] <= pins_s2.wdata[DCF_BYTE_W-1:0];
        DCF_SEL_FLO: fofs_r[DCF_BYTE_W-1:0]         <= pins_s2.wdata[DCF_BYTE_W-1:0];
        DCF_SEL_FHI: fofs_r[DCF_OFS_W-1:DCF_BYTE_W] <= pins_s2.wdata[DCF_BYTE_W-1:0];
      endcase
    end else if (axi_wr) begin
      // software write of an offset
      if (awaddr_r == DCF_ADDR_EOFS) begin
        eofs_r <= lane_merge(eofs_r, wdata_r, wstrb_r);
      end else if (awaddr_r == DCF_ADDR_FOFS) begin
        fofs_r <= lane_merge(fofs_r, wdata_r, wstrb_r);
      end
    end
  end

  // select steps and wraps to empty low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wsel_r <= DCF_SEL_ELO;
      rsel_r <= DCF_SEL_ELO;
    end else begin
      if (do_load) begin
        wsel_r <= dcf_sel_t'(wsel_r + 2'h1);
      end
      if (do_ofs_rd) begin
        rsel_r <= dcf_sel_t'(rsel_r + 2'h1);
      end
    end
  end

  // ****************************************************************
  // flags
  // ****************************************************************
  logic [PW-1:0] cnt_w;   // occupancy seen by write side
  logic [PW-1:0] cnt_r;   // occupancy seen by read side

  // read side seen late, full may lag
  assign cnt_w = PW'(wptr_nxt - gray2bin(rg_s2));
  // write side seen late, only matters near empty
  assign cnt_r = PW'(gray2bin(wg_s2) - rptr_nxt);

  // write-side flags on write edges only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r.full_n  <= 1'b1;
      flags_r.afull_n <= 1'b1;
    end else if (w_edge) begin
      flags_r.full_n  <= (cnt_w != DEPTH_C);
      flags_r.afull_n <= (17'(cnt_w) + 17'(fofs_r)) < DEPTH_T;
    end
  end

  // read-side flags on read edges only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_r.empty_n  <= 1'b0;
      flags_r.aempty_n <= 1'b0;
    end else if (r_edge) begin
      flags_r.empty_n  <= (cnt_r != '0);
      flags_r.aempty_n <= 17'(cnt_r) > 17'(eofs_r);
    end
  end

  assign full_flag_n         = flags_r.full_n;
  assign almost_full_flag_n  = flags_r.afull_n;
  assign almost_empty_flag_n = flags_r.aempty_n;
  assign empty_flag_n        = flags_r.empty_n;

  // ****************************************************************
  // output register
  // ****************************************************************
  logic [DCF_DATA_W-1:0] q_r;     // output register
  logic                  oe_n_r;  // registered output enable

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_r <= '0;
    end else if (do_pop) begin
      q_r <= mem[rptr_r[AW-1:0]];
    end else if (do_ofs_rd) begin
      // offset halves shown in load order
      unique case (rsel_r)
        DCF_SEL_ELO: q_r <= DCF_DATA_W'(eofs_r[DCF_BYTE_W-1:0]);
        DCF_SEL_EHI: q_r <= DCF_DATA_W'(eofs_r[DCF_OFS_W-1:DCF_BYTE_W]);
        DCF_SEL_FLO: q_r <= DCF_DATA_W'(fofs_r[DCF_BYTE_W-1:0]);
        DCF_SEL_FHI: q_r <= DCF_DATA_W'(fofs_r[DCF_OFS_W-1:DCF_BYTE_W]);
      endcase
    end
  end

  // drive only while output enable low
  always_ff @(posedge aclk) begin
    oe_n_r <= aresetn ? pins_s2.oe_n : 1'b1;
  end

  assign read_data_out  = q_r;
  assign read_data_oe_n = oe_n_r;

  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  logic aw_got_r, w_got_r;   // address / data held

  assign axi_wr = aw_got_r && w_got_r && !s_axi_bvalid;

  // write address and data capture, either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= '0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got_r      <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_r      <= s_axi_awaddr;
      end else if (axi_wr) begin
        aw_got_r      <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_got_r      <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
      end else if (axi_wr) begin
        w_got_r      <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // write response, slverr for unmapped or read-only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DCF_RESP_OKAY;
    end else if (axi_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == DCF_ADDR_EOFS || awaddr_r == DCF_ADDR_FOFS)
                      ? DCF_RESP_OKAY : DCF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read channel, one outstanding read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= DCF_RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= DCF_RESP_OKAY;
      s_axi_rdata   <= '0;
      unique case (s_axi_araddr)
        DCF_ADDR_STATUS: begin
          s_axi_rdata[DCF_ST_FULL_N]   <= flags_r.full_n;
          s_axi_rdata[DCF_ST_AFULL_N]  <= flags_r.afull_n;
          s_axi_rdata[DCF_ST_AEMPTY_N] <= flags_r.aempty_n;
          s_axi_rdata[DCF_ST_EMPTY_N]  <= flags_r.empty_n;
          s_axi_rdata[DCF_ST_LOADMODE] <= load_mode_r;
          s_axi_rdata[DCF_ST_COUNT_LO +: PW] <= PW'(wptr_r - gray2bin(rg_s2));
        end
        DCF_ADDR_EOFS: s_axi_rdata[DCF_OFS_W-1:0] <= eofs_r;
        DCF_ADDR_FOFS: s_axi_rdata[DCF_OFS_W-1:0] <= fofs_r;
        default:       s_axi_rresp <= DCF_RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_full_blocks_push: assert property (!flags_r.full_n |-> !do_push)
    else $error("word stored while full");
  a_full_on_wedge: assert property ($changed(flags_r.full_n) |-> $past(w_edge))
    else $error("full flag moved without write edge");
  a_empty_blocks_pop: assert property (rd_req && !flags_r.empty_n |=> $stable(rptr_r))
    else $error("read pointer moved while empty");
  a_empty_on_redge: assert property ($changed(flags_r.empty_n) |-> $past(r_edge))
    else $error("empty flag moved without read edge");
  a_afull_on_wedge: assert property ($changed(flags_r.afull_n) |-> $past(w_edge))
    else $error("almost-full moved without write edge");
  a_aempty_on_redge: assert property ($changed(flags_r.aempty_n) |-> $past(r_edge))
    else $error("almost-empty moved without read edge");
  a_flag_order: assert property (!flags_r.empty_n |-> !flags_r.aempty_n)
    else $error("empty low while almost-empty high");
  a_full_implies_af: assert property (!flags_r.full_n |-> !flags_r.afull_n)
    else $error("full low while almost-full high");
  a_sel_wrap: assert property (do_load && wsel_r == DCF_SEL_FHI |=> wsel_r == DCF_SEL_ELO)
    else $error("offset select did not wrap");
  a_mode_stable: assert property ($stable(load_mode_r))
    else $error("mode changed outside reset");
  a_reset_state: assert property (
    @(posedge aclk) disable iff (1'b0)
    !aresetn |=> (q_r == '0 && flags_r == 4'b1100 && wptr_r == '0 && eofs_r == DCF_OFS_DEFAULT))
    else $error("reset state wrong");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");

  c_reach_full:   cover property (!flags_r.full_n);
  c_empty_to_one: cover property (!flags_r.empty_n ##[1:40] flags_r.empty_n);
  c_offset_load:  cover property (do_load && wsel_r == DCF_SEL_FHI);
  c_axi_write:    cover property (axi_wr && s_axi_wstrb != 4'h0);

endmodule : dcf_fifo

//--- dcf_pkg.sv
// dual-clock fifo flag bank: shared constants and carrier types
// assumes one system clock; fifo pins arrive asynchronously and are synchronised
package dcf_pkg;

  // ****************************************************************
  // sizes and defaults
  // ****************************************************************
  localparam int          DCF_DATA_W        = 9;      // word width of the array
  localparam int          DCF_DEPTH_DEFAULT = 256;    // default array depth
  localparam int          DCF_OFS_W         = 16;     // offset width (two 8-bit halves)
  localparam int          DCF_BYTE_W        = 8;      // width of one offset half
  localparam logic [15:0] DCF_OFS_DEFAULT   = 16'h0007; // default offset n and m

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam int         DCF_AXI_AW       = 8;       // decoded address bits
  localparam logic [7:0] DCF_ADDR_STATUS  = 8'h00;   // flags, mode, occupancy
  localparam logic [7:0] DCF_ADDR_EOFS    = 8'h04;   // empty offset n
  localparam logic [7:0] DCF_ADDR_FOFS    = 8'h08;   // full offset m

  // status field positions
  localparam int DCF_ST_FULL_N   = 0;
  localparam int DCF_ST_AFULL_N  = 1;
  localparam int DCF_ST_AEMPTY_N = 2;
  localparam int DCF_ST_EMPTY_N  = 3;
  localparam int DCF_ST_LOADMODE = 4;
  localparam int DCF_ST_COUNT_LO = 16;

  // axi responses
  localparam logic [1:0] DCF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCF_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // types
  // ****************************************************************
  // offset register select sequence
  typedef enum logic [1:0] {
    DCF_SEL_ELO = 2'b00,
    DCF_SEL_EHI = 2'b01,
    DCF_SEL_FLO = 2'b10,
    DCF_SEL_FHI = 2'b11
  } dcf_sel_t;

  // asynchronous pin bundle, synchronised as one group
  typedef struct packed {
    logic                  wclk;
    logic                  rclk;
    logic                  write_enable_first_n_n;
    logic                  write_enable_second_ld;
    logic                  ren1_n;
    logic                  ren2_n;
    logic                  oe_n;
    logic [DCF_DATA_W-1:0] wdata;
  } dcf_pins_t;

  // status flags, all active low
  typedef struct packed {
    logic full_n;
    logic afull_n;
    logic aempty_n;
    logic empty_n;
  } dcf_flags_t;

endpackage : dcf_pkg

//--- dual_clock_fifo_status_flags_tb_top.sv
// testbench: fills and drains a 16-word fifo, checks flags over axi-lite
// assumes dcf_fifo and the controller model dcf_ctrl_model
`timescale 1ns/1ps
module dual_clock_fifo_status_flags_tb_top;
  import dcf_pkg::*;
  localparam int D = 16;
  logic aclk = 1'b0, aresetn = 1'b0, dchk = 1'b0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [8:0] read_data_out, write_data_in, d;
  logic read_data_oe_n, full_flag_n, almost_full_flag_n, almost_empty_flag_n, empty_flag_n;
  logic write_clock, read_clock, write_enable_first_n, write_enable_second_or_load;
  logic read_enable_first_n, read_enable_second_n, output_enable_n;
  logic [33:0] qa[$];
  logic [9:0] qd[$];
  logic [33:0] e;
  int mismatches = 0, samples_checked = 0, seed = 22, k;
  // clock, 5 ns period
  always #2.5 aclk = ~aclk;
  dcf_fifo #(.DEPTH(D)) uut (.aclk, .aresetn, .write_clock, .read_clock,
    .write_enable_first_n, .write_enable_second_or_load, .read_enable_first_n,
    .read_enable_second_n, .output_enable_n, .write_data_in, .read_data_out,
    .read_data_oe_n, .full_flag_n, .almost_full_flag_n, .almost_empty_flag_n,
    .empty_flag_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  dcf_ctrl_model m (.aclk, .write_clock, .read_clock, .write_enable_first_n,
    .write_enable_second_or_load, .read_enable_first_n, .read_enable_second_n,
    .output_enable_n, .write_data_in);
  // compare and count
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one look by the monitor at the data pins and their enable
  task automatic look;
    dchk <= 1'b1;
    @(posedge aclk);
    dchk <= 1'b0;
  endtask : look
  // status word expected for k words with offsets n and m
  function automatic logic [33:0] st(input int k, input int n, input int m);
    st = {18'(k), 12'h0, 1'(k != 0), 1'(k > n), 1'(k < D - m), 1'(k != D)};
  endfunction : st
  // axi-lite write, expected response noted first
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
    qa.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    fork
      begin do @(posedge aclk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : wr
  // axi-lite read, expected response and data noted first
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    qa.push_back(e);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : rd
  // monitor: answers and popped words against the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, qa.pop_front());
    if (s_axi_rvalid && s_axi_rready) begin
      e = qa.pop_front();
      chk({s_axi_rresp, s_axi_rdata}, e);
      // flag pins must agree with the expected status word
      if (s_axi_araddr == DCF_ADDR_STATUS)
        chk(34'({empty_flag_n, almost_empty_flag_n, almost_full_flag_n, full_flag_n}),
            34'(e[3:0]));
    end
    if (dchk) chk(34'({read_data_oe_n, read_data_out}), 34'(qd.pop_front()));
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // output register clear, drive still off at the first edge
    qd.push_back({1'b1, 9'h0});
    look();
    rd(DCF_ADDR_EOFS, 34'h7);
    rd(DCF_ADDR_FOFS, 34'h7);
    rd(DCF_ADDR_STATUS, st(0, 7, 7));
    rd(8'h0C, {DCF_RESP_SLVERR, 32'h0});
    wr(DCF_ADDR_STATUS, 32'h0, DCF_RESP_SLVERR);
    $display("reset test done");
    for (k = 1; k <= D + 1; k++) begin
      d = 9'($random(seed));
      if (k <= D) qd.push_back({1'b0, d});
      // last word kept again for the read while empty
      if (k == D) qd.push_back({1'b0, d});
      m.op(1'b1, 1'b0, d);
      repeat (2) m.op(1'b0, 1'b0, d);
      rd(DCF_ADDR_STATUS, st(k > D ? D : k, 7, 7));
    end
    $display("fill test done");
    // only byte lane 0 enabled: the high byte must keep its old value
    s_axi_wstrb <= 4'h1;
    wr(DCF_ADDR_EOFS, 32'h5503, DCF_RESP_OKAY);
    wr(DCF_ADDR_FOFS, 32'h2, DCF_RESP_OKAY);
    for (k = D - 1; k >= 0; k--) begin
      m.op(1'b0, 1'b1, d);
      look();
      repeat (2) m.op(1'b0, 1'b0, d);
      rd(DCF_ADDR_STATUS, st(k, 3, 2));
    end
    // a read while empty leaves the output register alone
    m.op(1'b0, 1'b1, d);
    look();
    $display("drain test done");
    // second reset straps load mode, pin clocks run during it
    m.strap(1'b0, 1'b1);
    aresetn <= 1'b0;
    m.op(1'b1, 1'b1, d);
    aresetn <= 1'b1;
    qd.push_back({1'b1, 9'h0});
    look();
    rd(DCF_ADDR_EOFS, 34'h7);
    // five loads wrap back to the empty low half
    for (k = 0; k < 5; k++) m.op(1'b1, 1'b0, 9'(k[0] ? 0 : k + 1));
    rd(DCF_ADDR_EOFS, 34'h5);
    rd(DCF_ADDR_FOFS, 34'h3);
    rd(DCF_ADDR_STATUS, st(0, 5, 3) | (34'h1 << DCF_ST_LOADMODE));
    // offset halves read back in load order, drive disabled
    for (k = 0; k < 4; k++) begin
      qd.push_back({1'b1, 9'(k[0] ? 0 : (k == 0 ? 5 : 3))});
      m.op(1'b0, 1'b1, d);
      look();
    end
    $display("load test done");
    end_of_test();
  end
endmodule : dual_clock_fifo_status_flags_tb_top
